/* File: verilog/jtm_defs.vh */
// Purpose: shared constants of the test port and debug mailbox
// Assumes: included by jtm_top.v and jtm_fifo.v
// Notes: codes of instructions and programming operations are local choices
`ifndef JTM_DEFS_VH
`define JTM_DEFS_VH

// ****************************************
// instruction register
// ****************************************
`define JTM_IR_W 4
`define JTM_IR_CAPTURE 4'h1
`define JTM_I_EXTEST 4'h0
`define JTM_I_IDCODE 4'h1
`define JTM_I_SAMPLE 4'h2
`define JTM_I_PROG 4'h4
`define JTM_I_MBOX 4'h8
`define JTM_I_BRKPT 4'hA
`define JTM_I_INTSCAN 4'hB
`define JTM_I_BYPASS 4'hF

// ****************************************
// data register lengths
// ****************************************
`define JTM_DR_W 32
`define JTM_LEN_W 6
`define JTM_LEN_ID 6'd32
`define JTM_LEN_BYP 6'd1
`define JTM_LEN_PROG 6'd24
`define JTM_LEN_MBOX 6'd10
`define JTM_LEN_BRK 6'd16
`define JTM_LEN_INT 6'd8

// ****************************************
// programming command layout
// ****************************************
`define JTM_OP_HI 23
`define JTM_OP_LO 20
`define JTM_ADDR_HI 19
`define JTM_ADDR_LO 8
`define JTM_ADDR_W 12
`define JTM_OP_NOP 4'h0
`define JTM_OP_FLASH_WR 4'h1
`define JTM_OP_EE_WR 4'h2
`define JTM_OP_FLASH_RD 4'h3
`define JTM_OP_EE_RD 4'h4
`define JTM_OP_LOCK_WR 4'h5
`define JTM_OP_FUSE_WR 4'h6
`define JTM_OP_ERASE 4'h7
`define JTM_OP_LOCK_RD 4'h8
`define JTM_OP_FUSE_RD 4'h9
`define JTM_KIND_FLASH 2'h0
`define JTM_KIND_EE 2'h1
`define JTM_KIND_ERASE 2'h2
`define JTM_REQ_W 22

// ****************************************
// mailbox and lock fields
// ****************************************
`define JTM_MBOX_CLR 8
`define JTM_MBOX_EN 9
`define JTM_MBOX_RST 8'h00
`define JTM_LOCK_RST 8'hFF
`define JTM_LB1 0
`define JTM_LB2 1

`endif

/* File: verilog/jtm_fifo.v */
// Purpose: small flop FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty come from a separate occupancy count
`include "jtm_defs.vh"
module jtm_fifo #(
  parameter WIDTH = `JTM_REQ_W,
  parameter DEPTH = 8
) (
  input wire MCLK,
  input wire RST_N,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  function integer jtm_log2;
    input integer v;
    integer n;
    begin
      n = 0;
      while ((1 << n) < v) n = n + 1;
      jtm_log2 = (n == 0) ? 1 : n;
    end
  endfunction
  localparam AW = jtm_log2(DEPTH);
  localparam [AW:0] FULL_CNT = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != FULL_CNT);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];

  always @(posedge MCLK) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge MCLK) begin
    if (!RST_N) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* File: verilog/jtm_top.v */
// Purpose: four-pin test access port with debug mailbox and programming port
// Assumes: TCK far slower than MCLK (at least 8 MCLK per TCK period)
// Notes: fuses and lock byte return to blank values on RST_N
//
// How it works
// - TMS alone steers the port state machine
// - instruction or one data register sits TDI-TDO
// - instruction picks data register and its behaviour
// - TDI shifted in, register LSB driven out
// - all port actions on sampled test clock edges
// - id, bypass, boundary, programming, debug chains
// - CPU mailbox write reaches the debugger
// - same CPU write sets the dirty flag
// - CPU read: seven low bits, dirty flag top
// - shared address: mailbox needs fuse and enable
// - port runs only with fuse, disable bit clear
// - flash, eeprom, fuse and lock programming, verify
// - lock protection same as parallel programming
// - locks programmed: debug fuse refused until erase
// - only chip erase or RST_N returns lock bits to one
`include "jtm_defs.vh"
module jtm_top #(
  parameter BSCAN_LEN = 8,
  parameter SHARED_IO = 1,
  parameter [31:0] IDCODE = 32'h0000_1001, // arbitrary value, lsb must be one
  parameter FIFO_DEPTH = 8
) (
  input wire MCLK,
  input wire RST_N,
  input wire TCK,
  input wire TMS,
  input wire TDI,
  output reg TDO,
  output reg TDO_OE,
  input wire TEST_PORT_ENABLE_FUSE_N,
  input wire TEST_PORT_DISABLE_BIT,
  input wire CPU_SEL,
  input wire CPU_WE,
  input wire CPU_RE,
  input wire [7:0] CPU_WDATA,
  output reg [7:0] CPU_RDATA,
  output wire CPU_MBOX_HIT,
  input wire [BSCAN_LEN-1:0] BSCAN_IN,
  output reg [BSCAN_LEN-1:0] BSCAN_OUT,
  output reg BSCAN_EXTEST,
  input wire [7:0] DBG_CORE_STATE,
  output reg [15:0] DBG_BREAK_ADDR,
  output wire NVM_VALID,
  input wire NVM_READY,
  output wire [1:0] NVM_KIND,
  output wire [`JTM_ADDR_W-1:0] NVM_ADDR,
  output wire [7:0] NVM_WDATA,
  output reg NVM_RD_EE,
  output reg [`JTM_ADDR_W-1:0] NVM_RADDR,
  input wire [7:0] NVM_RDATA
);
  // ****************************************
  // port states
  // ****************************************
  localparam [3:0] S_TLR = 4'h0, S_RTI = 4'h1, S_SELDR = 4'h2, S_CAPDR = 4'h3;
  localparam [3:0] S_SHDR = 4'h4, S_EX1DR = 4'h5, S_PSDR = 4'h6, S_EX2DR = 4'h7;
  localparam [3:0] S_UPDR = 4'h8, S_SELIR = 4'h9, S_CAPIR = 4'hA, S_SHIR = 4'hB;
  localparam [3:0] S_EX1IR = 4'hC, S_PSIR = 4'hD, S_EX2IR = 4'hE, S_UPIR = 4'hF;

  function [3:0] jtm_next;
    input [3:0] s;
    input m;
    begin
      case (s)
        S_TLR: jtm_next = m ? S_TLR : S_RTI;
        S_RTI: jtm_next = m ? S_SELDR : S_RTI;
        S_SELDR: jtm_next = m ? S_SELIR : S_CAPDR;
        S_CAPDR: jtm_next = m ? S_EX1DR : S_SHDR;
        S_SHDR: jtm_next = m ? S_EX1DR : S_SHDR;
        S_EX1DR: jtm_next = m ? S_UPDR : S_PSDR;
        S_PSDR: jtm_next = m ? S_EX2DR : S_PSDR;
        S_EX2DR: jtm_next = m ? S_UPDR : S_SHDR;
        S_UPDR: jtm_next = m ? S_SELDR : S_RTI;
        S_SELIR: jtm_next = m ? S_TLR : S_CAPIR;
        S_CAPIR: jtm_next = m ? S_EX1IR : S_SHIR;
        S_SHIR: jtm_next = m ? S_EX1IR : S_SHIR;
        S_EX1IR: jtm_next = m ? S_UPIR : S_PSIR;
        S_PSIR: jtm_next = m ? S_EX2IR : S_PSIR;
        S_EX2IR: jtm_next = m ? S_UPIR : S_SHIR;
        S_UPIR: jtm_next = m ? S_SELDR : S_RTI;
        default: jtm_next = S_TLR;
      endcase
    end
  endfunction

  function [5:0] jtm_len;
    input [3:0] i;
    begin
      case (i)
        `JTM_I_EXTEST, `JTM_I_SAMPLE: jtm_len = BSCAN_LEN[5:0];
        `JTM_I_IDCODE: jtm_len = `JTM_LEN_ID;
        `JTM_I_PROG: jtm_len = `JTM_LEN_PROG;
        `JTM_I_MBOX: jtm_len = `JTM_LEN_MBOX;
        `JTM_I_BRKPT: jtm_len = `JTM_LEN_BRK;
        `JTM_I_INTSCAN: jtm_len = `JTM_LEN_INT;
        default: jtm_len = `JTM_LEN_BYP;
      endcase
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [2:0] tck_s;
  reg [1:0] tms_s;
  reg [1:0] tdi_s;
  reg [1:0] fuse_s;
  always @(posedge MCLK) begin
    if (!RST_N) begin
      tck_s <= 3'h0;
      tms_s <= 2'h0;
      tdi_s <= 2'h0;
      fuse_s <= 2'h3;
    end else begin
      tck_s <= {tck_s[1:0], TCK};
      tms_s <= {tms_s[0], TMS};
      tdi_s <= {tdi_s[0], TDI};
      fuse_s <= {fuse_s[0], TEST_PORT_ENABLE_FUSE_N};
    end
  end
  wire tck_r = tck_s[1] && !tck_s[2];
  wire tck_f = !tck_s[1] && tck_s[2];
  wire tap_en = !fuse_s[1] && !TEST_PORT_DISABLE_BIT;

  // ****************************************
  // port state, instruction, shift path
  // ****************************************
  reg [3:0] state;
  reg [3:0] ir;
  reg [3:0] ir_sh;
  reg [`JTM_DR_W-1:0] dr;
  reg [7:0] lock_byte;
  reg dbg_fuse_n;
  reg access_en;
  reg dirty;
  reg [7:0] mbox;
  reg refused;
  reg [7:0] rd_val;
  reg [3:0] rd_op;
  reg [`JTM_DR_W-1:0] next_dr;
  reg [`JTM_DR_W-1:0] cap_val;
  integer k;

  // private debug chains fall back to bypass on a part without the debug fuse
  wire dbg_ok = !dbg_fuse_n;
  wire priv = (ir == `JTM_I_MBOX) || (ir == `JTM_I_BRKPT) || (ir == `JTM_I_INTSCAN);
  wire [3:0] instr = (priv && !dbg_ok) ? `JTM_I_BYPASS : ir;
  wire [5:0] len = jtm_len(instr);
  wire step = tck_r && tap_en;
  wire upd_dr = step && (state == S_UPDR);
  wire [3:0] op = dr[`JTM_OP_HI:`JTM_OP_LO];
  wire lb1p = !lock_byte[`JTM_LB1];
  wire lb2p = !lock_byte[`JTM_LB2];
  wire wr_block = lb1p || lb2p;
  wire rd_block = lb1p && lb2p;
  wire fifo_ready;
  wire fifo_full = !fifo_ready;
  wire nvm_op = (op == `JTM_OP_FLASH_WR) || (op == `JTM_OP_EE_WR) || (op == `JTM_OP_ERASE);
  wire nvm_allowed = (op == `JTM_OP_ERASE) || !wr_block;
  wire prog_upd = upd_dr && (instr == `JTM_I_PROG);
  wire req_push = prog_upd && nvm_op && nvm_allowed;
  wire [1:0] req_kind = (op == `JTM_OP_EE_WR) ? `JTM_KIND_EE :
                        (op == `JTM_OP_ERASE) ? `JTM_KIND_ERASE : `JTM_KIND_FLASH;
  wire mbox_clr = upd_dr && (instr == `JTM_I_MBOX) && dr[`JTM_MBOX_CLR];

  always @* begin
    next_dr = {`JTM_DR_W{1'b0}};
    for (k = 0; k < `JTM_DR_W; k = k + 1) begin
      if (k == len - 1) begin
        next_dr[k] = tdi_s[1];
      end else if (k < len - 1) begin
        next_dr[k] = dr[k+1];
      end
    end
  end

  always @* begin
    cap_val = {`JTM_DR_W{1'b0}};
    case (instr)
      `JTM_I_EXTEST, `JTM_I_SAMPLE: cap_val[BSCAN_LEN-1:0] = BSCAN_IN;
      `JTM_I_IDCODE: cap_val = IDCODE;
      `JTM_I_PROG: cap_val[23:0] = {fifo_full, refused, 2'b00, NVM_RADDR, rd_val};
      `JTM_I_MBOX: cap_val[9:0] = {access_en, dirty, mbox};
      `JTM_I_BRKPT: cap_val[15:0] = DBG_BREAK_ADDR;
      `JTM_I_INTSCAN: cap_val[7:0] = DBG_CORE_STATE;
      default: cap_val[0] = 1'b0;
    endcase
  end

  always @(posedge MCLK) begin
    if (!RST_N || !tap_en) begin
      state <= S_TLR;
      ir <= `JTM_I_IDCODE;
      ir_sh <= `JTM_IR_CAPTURE;
      dr <= {`JTM_DR_W{1'b0}};
      TDO <= 1'b0;
      TDO_OE <= 1'b0;
    end else begin
      if (step) begin
        state <= jtm_next(state, tms_s[1]);
        case (state)
          S_TLR: ir <= `JTM_I_IDCODE;
          S_CAPIR: ir_sh <= `JTM_IR_CAPTURE;
          S_SHIR: ir_sh <= {tdi_s[1], ir_sh[3:1]};
          S_UPIR: ir <= ir_sh;
          S_CAPDR: dr <= cap_val;
          S_SHDR: dr <= next_dr;
          default: ir <= ir;
        endcase
      end
      if (tck_f) begin
        TDO <= (state == S_SHIR) ? ir_sh[0] : dr[0];
        TDO_OE <= (state == S_SHIR) || (state == S_SHDR);
      end
    end
  end

  // ****************************************
  // data register updates
  // ****************************************
  always @(posedge MCLK) begin
    if (!RST_N) begin
      BSCAN_OUT <= {BSCAN_LEN{1'b0}};
      BSCAN_EXTEST <= 1'b0;
      DBG_BREAK_ADDR <= 16'h0000;
      access_en <= 1'b0;
    end else begin
      BSCAN_EXTEST <= tap_en && (instr == `JTM_I_EXTEST);
      if (upd_dr && (instr == `JTM_I_EXTEST)) begin
        BSCAN_OUT <= dr[BSCAN_LEN-1:0];
      end
      if (upd_dr && (instr == `JTM_I_BRKPT)) begin
        DBG_BREAK_ADDR <= dr[15:0];
      end
      if (upd_dr && (instr == `JTM_I_MBOX)) begin
        access_en <= dr[`JTM_MBOX_EN] && dbg_ok;
      end
    end
  end

  // ****************************************
  // programming, fuse and lock bits
  // ****************************************
  always @(posedge MCLK) begin
    if (!RST_N) begin
      lock_byte <= `JTM_LOCK_RST;
      dbg_fuse_n <= 1'b1;
      refused <= 1'b0;
      rd_val <= 8'h00;
      rd_op <= `JTM_OP_NOP;
      NVM_RD_EE <= 1'b0;
      NVM_RADDR <= {`JTM_ADDR_W{1'b0}};
    end else if (prog_upd) begin
      refused <= 1'b0;
      case (op)
        `JTM_OP_FLASH_WR, `JTM_OP_EE_WR: refused <= wr_block || fifo_full;
        `JTM_OP_ERASE: begin
          refused <= fifo_full;
          if (fifo_ready) begin
            lock_byte <= `JTM_LOCK_RST;
          end
        end
        // lock bits only move toward programmed outside an erase
        `JTM_OP_LOCK_WR: lock_byte <= lock_byte & dr[7:0];
        `JTM_OP_FUSE_WR: begin
          if (wr_block) begin
            refused <= 1'b1;
          end else begin
            dbg_fuse_n <= dr[0];
          end
        end
        `JTM_OP_FLASH_RD, `JTM_OP_EE_RD: begin
          NVM_RD_EE <= (op == `JTM_OP_EE_RD);
          NVM_RADDR <= dr[`JTM_ADDR_HI:`JTM_ADDR_LO];
          refused <= rd_block;
        end
        default: refused <= 1'b0;
      endcase
      rd_op <= op;
    end else begin
      case (rd_op)
        `JTM_OP_FLASH_RD, `JTM_OP_EE_RD: rd_val <= rd_block ? 8'h00 : NVM_RDATA;
        `JTM_OP_LOCK_RD: rd_val <= lock_byte;
        `JTM_OP_FUSE_RD: rd_val <= {7'h7F, dbg_fuse_n};
        default: rd_val <= rd_val;
      endcase
    end
  end

  // back-pressure: a full queue refuses the write, visible in capture status
  jtm_fifo #(.WIDTH(`JTM_REQ_W), .DEPTH(FIFO_DEPTH)) u_req_fifo (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .in_valid(req_push),
    .in_ready(fifo_ready),
    .in_data({req_kind, dr[`JTM_ADDR_HI:`JTM_ADDR_LO], dr[7:0]}),
    .out_valid(NVM_VALID),
    .out_ready(NVM_READY),
    .out_data({NVM_KIND, NVM_ADDR, NVM_WDATA})
  );

  // ****************************************
  // cpu side mailbox
  // ****************************************
  assign CPU_MBOX_HIT = CPU_SEL && ((SHARED_IO == 0) || (dbg_ok && access_en));
  wire cpu_wr = CPU_MBOX_HIT && CPU_WE;

  always @(posedge MCLK) begin
    if (!RST_N) begin
      mbox <= `JTM_MBOX_RST;
      dirty <= 1'b0;
      CPU_RDATA <= 8'h00;
    end else begin
      if (cpu_wr) begin
        mbox <= CPU_WDATA;
      end
      // a write in the clearing cycle keeps the flag set
      if (cpu_wr) begin
        dirty <= 1'b1;
      end else if (mbox_clr) begin
        dirty <= 1'b0;
      end
      if (CPU_MBOX_HIT && CPU_RE) begin
        CPU_RDATA <= {dirty, mbox[6:0]};
      end else begin
        CPU_RDATA <= 8'h00;
      end
    end
  end
endmodule

/* File: tb/jtm_dbg.sv */
// Purpose: debugger model on the four test port pins
// Assumes: the device samples the pins with its own clock
// Notes: tck stands low between frames
module jtm_dbg (
  output logic TCK,
  output logic TMS,
  output logic TDI,
  input logic TDO
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // pin driver
  // ****
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  // 320 ns period, tdo taken at the rising edge
  task automatic bit_t(input logic tms, input logic tdi, output logic tdo);
    TMS = tms;
    TDI = tdi;
    #160 TCK = 1'b1;
    tdo = TDO;
    #160 TCK = 1'b0;
  endtask
  // idle tdi flips so a stale bit is never mistaken for data
  task automatic tap_reset;
    logic d;
    repeat (5) bit_t(1'b1, ~TDI, d);
    bit_t(1'b0, ~TDI, d);
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic d;
    dout = '0;
    bit_t(1'b1, ~TDI, d);
    if (ir) bit_t(1'b1, ~TDI, d);
    bit_t(1'b0, ~TDI, d);
    bit_t(1'b0, ~TDI, d);
    for (int i = 0; i < n; i++) begin
      bit_t(i == n - 1, din[i], d);
      dout[i] = d;
    end
    bit_t(1'b1, ~TDI, d);
    bit_t(1'b0, ~TDI, d);
  endtask
endmodule

/* File: tb/jtm_top_sva.sv */
// Purpose: port checks of test port and mailbox
// Assumes: single clock domain
// Notes: bound to jtm_top below
`include "jtm_defs.vh"
module jtm_chk (
  input wire MCLK,
  input wire RST_N,
  input wire TCK,
  input wire TDO,
  input wire TDO_OE,
  input wire TEST_PORT_ENABLE_FUSE_N,
  input wire TEST_PORT_DISABLE_BIT,
  input wire CPU_SEL,
  input wire CPU_WE,
  input wire CPU_RE,
  input wire [7:0] CPU_WDATA,
  input wire [7:0] CPU_RDATA,
  input wire CPU_MBOX_HIT,
  input wire NVM_VALID,
  input wire NVM_READY,
  input wire [1:0] NVM_KIND,
  input wire [`JTM_ADDR_W-1:0] NVM_ADDR,
  input wire [7:0] NVM_WDATA
);
  // ****
  // properties
  // ****
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_rd_idle;
    !CPU_RE |=> CPU_RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_rd_miss;
    CPU_RE && !CPU_MBOX_HIT |=> CPU_RDATA == 8'h00;
  endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("read without hit");
  sequence s_wr_rd;
    CPU_MBOX_HIT && CPU_WE ##1 CPU_MBOX_HIT && CPU_RE && !CPU_WE;
  endsequence
  property p_wr_rd;
    s_wr_rd |=> CPU_RDATA == ($past(CPU_WDATA, 2) | 8'h80);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("mailbox readback");
  property p_hit;
    CPU_MBOX_HIT |-> CPU_SEL;
  endproperty
  a_hit: assert property (p_hit) else $error("hit without select");
  property p_dis;
    TEST_PORT_DISABLE_BIT [*4] |-> !TDO_OE;
  endproperty
  a_dis: assert property (p_dis) else $error("tdo driven while disabled");
  property p_nofuse;
    TEST_PORT_ENABLE_FUSE_N [*6] |-> !TDO_OE;
  endproperty
  a_nofuse: assert property (p_nofuse) else $error("tdo driven without fuse");
  property p_nvm_hold;
    NVM_VALID && !NVM_READY |=> NVM_VALID && $stable({NVM_KIND, NVM_ADDR, NVM_WDATA});
  endproperty
  a_nvm_hold: assert property (p_nvm_hold) else $error("nvm request dropped");
  property p_nvm_kind;
    NVM_VALID |-> NVM_KIND != 2'h3;
  endproperty
  a_nvm_kind: assert property (p_nvm_kind) else $error("bad nvm kind");
  // tdo may only move after a falling test clock
  property p_tdo_still;
    TCK [*4] |-> $stable(TDO) && $stable(TDO_OE);
  endproperty
  a_tdo_still: assert property (p_tdo_still) else $error("tdo moved with tck high");
  c_wr_rd: cover property (s_wr_rd);
  c_nvm: cover property (NVM_VALID && NVM_READY);
  c_shift: cover property (TDO_OE);
endmodule
bind jtm_top jtm_chk jtm_chk_inst (.MCLK, .RST_N, .TCK, .TDO, .TDO_OE, .TEST_PORT_ENABLE_FUSE_N,
  .TEST_PORT_DISABLE_BIT, .CPU_SEL, .CPU_WE, .CPU_RE, .CPU_WDATA, .CPU_RDATA, .CPU_MBOX_HIT,
  .NVM_VALID, .NVM_READY, .NVM_KIND, .NVM_ADDR, .NVM_WDATA);

/* File: tb/test_jtag_tap_debug_mailbox.sv */
// Purpose: self-checking bench of test port and mailbox
// Assumes: debugger model on the pins, bench on cpu and nvm sides
// Notes: fixed seed, corner cases by hand
`include "jtm_defs.vh"
module test_jtag_tap_debug_mailbox;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID = 32'h0000_2003; // arbitrary value, lsb one
  localparam logic [3:0] PRIV [4] = '{`JTM_I_MBOX, `JTM_I_BRKPT, `JTM_I_INTSCAN, 4'h3};
  logic mclk = 1'b0, rst_n = 1'b0, fuse_n = 1'b0, dis = 1'b0, sel = 1'b1, we = 1'b0, re = 1'b0;
  logic rdy = 1'b0, stall = 1'b0, tck, tms, tdi, tdo, tdo_oe, hit, ext, nv, rd_ee;
  logic [7:0] wd = 8'h00, bin = 8'h00, core = 8'h00, rd, bout, nwd, nrd, v8;
  logic [15:0] brk;
  logic [1:0] kind;
  logic [11:0] addr, raddr;
  logic [31:0] st, r;
  logic [21:0] exp_q[$], got_q[$];
  int n_errors = 0;
  int compares = 0;
  int oe_cyc = 0, o = 0;
  jtm_top #(.IDCODE(ID)) jtm_top_inst (
    .MCLK(mclk), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
    .TEST_PORT_ENABLE_FUSE_N(fuse_n), .TEST_PORT_DISABLE_BIT(dis), .CPU_SEL(sel), .CPU_WE(we),
    .CPU_RE(re), .CPU_WDATA(wd), .CPU_RDATA(rd), .CPU_MBOX_HIT(hit), .BSCAN_IN(bin), .BSCAN_OUT(bout),
    .BSCAN_EXTEST(ext), .DBG_CORE_STATE(core), .DBG_BREAK_ADDR(brk), .NVM_VALID(nv), .NVM_READY(rdy),
    .NVM_KIND(kind), .NVM_ADDR(addr), .NVM_WDATA(nwd), .NVM_RD_EE(rd_ee), .NVM_RADDR(raddr),
    .NVM_RDATA(nrd));
  jtm_dbg jtm_dbg_inst (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo));
  // ****
  // helpers
  // ****
  initial begin
    forever #20 mclk = ~mclk;
  end
  function automatic logic [7:0] mem(input logic [11:0] a, input logic ee);
    return a[7:0] ^ {ee, 7'h5a};
  endfunction
  function automatic logic [31:0] bypass(input logic [31:0] d, input int n);
    return {d[30:0], 1'b0} & ((32'h1 << n) - 1);
  endfunction
  assign nrd = mem(raddr, rd_ee);
  always @(negedge mclk) rdy <= !stall && ($urandom % 4 != 0);
  always @(posedge mclk) if (nv && rdy) got_q.push_back({kind, addr, nwd});
  // cycles with tdo driven, one tck period is 320 / 40 clocks
  always @(posedge mclk) if (tdo_oe === 1'b1) oe_cyc <= oe_cyc + 1;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sc(input logic ir, input int n, input logic [31:0] din);
    jtm_dbg_inst.scan(ir, n, din, st);
  endtask
  task automatic irs(input logic [3:0] code);
    sc(1'b1, 4, {28'h000_0000, code});
    chk("ir capture", 32'h0000_0001, st);
  endtask
  task automatic prog(input logic [3:0] op, input logic [11:0] a, input logic [7:0] d);
    sc(1'b0, 24, {8'h00, op, a, d});
  endtask
  // called at a falling edge, so a write and a read run back to back
  task automatic cpu_wr(input logic [7:0] d);
    we = 1'b1;
    wd = d;
    @(negedge mclk);
    we = 1'b0;
  endtask
  task automatic cpu_rd(output logic [7:0] d);
    re = 1'b1;
    @(negedge mclk);
    re = 1'b0;
    d = rd;
  endtask
  task automatic final_report;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #2_400_000;
    n_errors++;
    final_report;
  end
  // ****
  // tests
  // ****
  initial begin
    void'($urandom(32'h56f1_2f53));
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk("oe after reset", 0, {tdo_oe, nv});
    cpu_wr(8'h5a);
    cpu_rd(v8);
    chk("mailbox hidden", 0, {hit, v8});
    jtm_dbg_inst.tap_reset();
    o = oe_cyc;
    sc(1'b0, 32, $urandom);
    chk("idcode", ID, st);
    chk("oe cycles", 32 * 320 / 40, oe_cyc - o);
    irs(`JTM_I_BYPASS);
    r = $urandom;
    sc(1'b0, 8, r);
    chk("bypass", bypass(r, 8), st);
    for (int i = 0; i < 4; i++) begin
      irs(PRIV[i]);
      r = $urandom;
      sc(1'b0, 8, r);
      chk("private as bypass", bypass(r, 8), st);
    end
    @(negedge mclk) bin = $urandom;
    irs(`JTM_I_SAMPLE);
    sc(1'b0, 8, 0);
    chk("sample", bin, st);
    irs(`JTM_I_EXTEST);
    r = $urandom;
    sc(1'b0, 8, r);
    chk("extest", {1'b1, r[7:0]}, {ext, bout});
    irs(`JTM_I_PROG);
    for (int e = 0; e < 2; e++) begin
      r = $urandom;
      prog(4'(3 + e), r[11:0], 8'h00);
      prog(4'h0, 12'h000, 8'h00);
      chk("nvm read", {4'h0, r[11:0], mem(r[11:0], e[0])}, st);
    end
    prog(4'h5, 12'h000, 8'hfc);
    prog(4'h8, 12'h000, 8'h00);
    prog(4'h3, r[11:0], 8'h00);
    chk("lock byte", 8'hfc, st[7:0]);
    prog(4'h1, r[11:0], 8'h33);
    chk("locked read", 0, st[7:0]);
    prog(4'h6, 12'h000, 8'hfe);
    chk("locked write", 1, st[22]);
    prog(4'h9, 12'h000, 8'h00);
    prog(4'h7, 12'h000, 8'h00);
    chk("fuse refused", 8'hff, st[7:0]);
    exp_q.push_back(22'h20_0000);
    prog(4'h8, 12'h000, 8'h00);
    prog(4'h6, 12'h000, 8'hfe);
    chk("lock erased", 8'hff, st[7:0]);
    prog(4'h9, 12'h000, 8'h00);
    prog(4'h0, 12'h000, 8'h00);
    chk("fuse taken", 8'hfe, st[7:0]);
    @(negedge mclk) stall = 1'b1;
    for (int i = 0; i < 9; i++) begin
      r = $urandom;
      prog(4'h1 + r[12], r[11:0], r[20:13]);
      if (i < 8) exp_q.push_back({1'b0, r[12], r[11:0], r[20:13]});
    end
    prog(4'h0, 12'h000, 8'h00);
    chk("fifo full", 2'h3, st[23:22]);
    @(negedge mclk) stall = 1'b0;
    for (int i = 0; i < 1000 && got_q.size() < exp_q.size(); i++) @(negedge mclk);
    chk("nvm count", exp_q.size(), got_q.size());
    foreach (exp_q[i]) chk("nvm request", exp_q[i], got_q[i]);
    irs(`JTM_I_MBOX);
    sc(1'b0, 10, 32'h0000_0200);
    chk("mailbox capture", 0, st);
    @(negedge mclk);
    for (int i = 0; i < 3; i++) begin
      r = $urandom;
      cpu_wr(r[7:0]);
      cpu_rd(v8);
      chk("mailbox read", {2'b11, r[6:0]}, {hit, v8});
    end
    // an unselected write must leave the mailbox alone
    sel = 1'b0;
    cpu_wr(~r[7:0]);
    cpu_rd(v8);
    chk("unselected read", 0, {hit, v8});
    sel = 1'b1;
    sc(1'b0, 10, 32'h0000_0300);
    chk("debugger view", {2'h3, r[7:0]}, st);
    @(negedge mclk);
    cpu_rd(v8);
    chk("dirty cleared", {1'b0, r[6:0]}, v8);
    irs(`JTM_I_BRKPT);
    r = $urandom;
    sc(1'b0, 16, r);
    chk("break chain", r[15:0], {st[15:0], brk});
    @(negedge mclk) core = $urandom;
    irs(`JTM_I_INTSCAN);
    sc(1'b0, 8, 0);
    chk("core chain", core, st);
    @(negedge mclk) dis = 1'b1;
    o = oe_cyc;
    sc(1'b0, 32, 0);
    chk("disabled port", 0, st);
    chk("disabled oe", 0, oe_cyc - o);
    @(negedge mclk) dis = 1'b0;
    fuse_n = 1'b1;
    sc(1'b0, 32, 0);
    chk("unfused port", 0, st);
    @(negedge mclk) fuse_n = 1'b0;
    repeat (4) @(negedge mclk);
    jtm_dbg_inst.tap_reset();
    sc(1'b0, 32, 0);
    chk("port back", ID, st);
    final_report;
  end
endmodule
